// >>> rtl/serial_baud_rate_generator.sv
// What this block does
// - divider eight bits, sixteen when wide select
// - divider free runs, period from divisor pair
// - async prescale set by speed and width
// - sync mode ignores the high speed bit
// - divisor write clears the divider at once
// - async narrow slow: clock over 64(n+1)
// - wake sets receive flag, then clears enable
// - wake off or sync mode: normal receive
// - async wide slow: clock over 16(n+1)
// - sync mode: clock over 4(n+1)
module serial_baud_rate_generator
  import rate_gen_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // receive side
  input  wire logic        rx_pin_i,
  input  wire logic        receive_idle_flag_i,
  // to shift logic
  output logic             rate_tick_o,
  output logic             receive_interrupt_flag_set_o,
  output logic             clock_polarity_o,
  output logic             sync_mode_o,
  // interrupt
  output logic             irq_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic                wide_divider_select_r;
  logic                high_speed_select_r;
  logic                wake_on_receive_enable_r;
  logic                auto_rate_detect_enable_r;
  logic                detect_overflow_r;
  logic [15:0]         divisor_r;
  logic [IRQ_W-1:0]    irq_status_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic [IRQ_W-1:0]    irq_event;
  logic                access;
  logic                wr_en;
  logic                rd_en;
  logic [31:0]         rd_data;
  logic                wr_control;
  logic                wr_divisor;
  logic                rx_level;
  logic                rx_prev_r;
  logic                rx_fall;
  logic                rx_rise;
  logic                wake_event;
  logic                wake_clear_r;
  detect_state_t       det_state_r;
  logic [15:0]         det_count_r;
  logic [15:0]         det_limit;
  logic                det_done;
  logic                det_ovf;
  logic                det_active;
  logic                pre_tick;
  logic                divider_tick;
  logic                divider_clear;
  logic [15:0]         divider_count;
  logic [7:0]          control_view;

  // ************************************************************
  // bus decode
  // ************************************************************
  // one wait state: ack follows the request by one edge; writes
  // land on the edge where the master samples ack, not before
  assign access     = cyc_i && stb_i && !ack_o;
  assign wr_en      = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign rd_en      = access && !we_i;
  assign wr_control = wr_en && (adr_i == OFS_CONTROL);
  assign wr_divisor = wr_en && ((adr_i == OFS_DIVISOR_LOW) ||
                                (adr_i == OFS_DIVISOR_HI));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // ************************************************************
  // receive pin and edges
  // ************************************************************
  pin_sync rx_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (rx_pin_i),
    .level_o (rx_level)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_prev_r <= RX_IDLE_LVL;
    end else begin
      rx_prev_r <= rx_level;
    end
  end

  assign rx_fall = rx_prev_r && !rx_level;
  assign rx_rise = !rx_prev_r && rx_level;

  // ************************************************************
  // mode and control bits
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_mode_o         <= BIT_RST;
      high_speed_select_r <= BIT_RST;
    end else if (wr_en && (adr_i == OFS_MODE)) begin
      sync_mode_o         <= dat_i[MODE_SYNC];
      high_speed_select_r <= dat_i[MODE_HIGH_SPD];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_divider_select_r <= BIT_RST;
      clock_polarity_o      <= BIT_RST;
    end else if (wr_control) begin
      wide_divider_select_r <= dat_i[CTL_WIDE];
      clock_polarity_o      <= dat_i[CTL_POLARITY];
    end
  end

  // ************************************************************
  // wake on receive
  // ************************************************************
  // a start edge while armed wakes the receiver, async only
  assign wake_event = wake_on_receive_enable_r && !sync_mode_o &&
                      rx_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_interrupt_flag_set_o <= 1'b0;
      wake_clear_r                 <= 1'b0;
    end else begin
      receive_interrupt_flag_set_o <= wake_event;
      wake_clear_r                 <= wake_event;
    end
  end

  // the enable drops one cycle after the flag is raised; a software
  // write landing in that same cycle loses to the hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_on_receive_enable_r <= BIT_RST;
    end else if (wake_clear_r) begin
      wake_on_receive_enable_r <= 1'b0;
    end else if (wr_control) begin
      wake_on_receive_enable_r <= dat_i[CTL_WAKE];
    end
  end

  // ************************************************************
  // rate detection
  // ************************************************************
  // measures one start bit in prescaled units; the divisor that
  // gives that bit time is the count less one
  assign det_limit  = wide_divider_select_r ? 16'hffff : 16'h00ff;
  assign det_active = auto_rate_detect_enable_r && !sync_mode_o;
  assign det_ovf    = (det_state_r == DET_MEASURE) && det_active &&
                      pre_tick && (det_count_r == det_limit);
  assign det_done   = (det_state_r == DET_MEASURE) && det_active &&
                      !det_ovf && rx_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_state_r <= DET_IDLE;
    end else if (!det_active) begin
      det_state_r <= DET_IDLE;
    end else begin
      case (det_state_r)
        DET_IDLE: begin
          det_state_r <= DET_ARMED;
        end
        DET_ARMED: begin
          if (rx_fall) begin
            det_state_r <= DET_MEASURE;
          end
        end
        DET_MEASURE: begin
          if (det_done || det_ovf) begin
            det_state_r <= DET_IDLE;
          end
        end
        default: begin
          det_state_r <= DET_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || det_state_r != DET_MEASURE) begin
      det_count_r <= 16'h0000;
    end else if (pre_tick && det_count_r != det_limit) begin
      det_count_r <= det_count_r + 16'h0001;
    end
  end

  // enable self clears when detection ends; a set from software
  // in that same cycle is taken as a new request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_rate_detect_enable_r <= BIT_RST;
    end else if (wr_control) begin
      auto_rate_detect_enable_r <= dat_i[CTL_DETECT];
    end else if (det_done || det_ovf) begin
      auto_rate_detect_enable_r <= 1'b0;
    end
  end

  // overflow is set by hardware and wins over a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_overflow_r <= BIT_RST;
    end else if (det_ovf) begin
      detect_overflow_r <= 1'b1;
    end else if (wr_control) begin
      detect_overflow_r <= dat_i[CTL_DETECT_OVF];
    end
  end

  // ************************************************************
  // divisor pair
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divisor_r <= DIVISOR_RST;
    end else if (det_done) begin
      divisor_r <= (det_count_r == 16'h0000) ? 16'h0000 :
                   det_count_r - 16'h0001;
    end else if (wr_en && adr_i == OFS_DIVISOR_LOW) begin
      divisor_r[7:0] <= dat_i[7:0];
    end else if (wr_en && adr_i == OFS_DIVISOR_HI) begin
      divisor_r[15:8] <= dat_i[7:0];
    end
  end

  // clear lands with the new divisor, so the old count never runs out
  assign divider_clear = wr_divisor || det_done;

  rate_divider divider (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .clear_i      (divider_clear),
    .sync_mode_i  (sync_mode_o),
    .wide_i       (wide_divider_select_r),
    .high_speed_i (high_speed_select_r),
    .divisor_i    (divisor_r),
    .pre_tick_o   (pre_tick),
    .tick_o       (divider_tick),
    .count_o      (divider_count)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_tick_o <= 1'b0;
    end else begin
      rate_tick_o <= divider_tick;
    end
  end

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  assign irq_event = {det_ovf, det_done, wake_event};

  genvar b;
  generate
    for (b = 0; b < IRQ_W; b = b + 1) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          irq_status_r[b] <= 1'b0;
        end else if (irq_event[b]) begin
          irq_status_r[b] <= 1'b1;
        end else if (wr_en && adr_i == OFS_IRQ_STATUS && dat_i[b]) begin
          irq_status_r[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_en && adr_i == OFS_IRQ_MASK) begin
      irq_mask_r <= dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  // idle flag is read live so software can check it before a
  // clock change; the receiver drives it from this same clock
  always_comb begin
    control_view                 = 8'h00;
    control_view[CTL_DETECT_OVF] = detect_overflow_r;
    control_view[CTL_RX_IDLE]    = receive_idle_flag_i;
    control_view[CTL_POLARITY]   = clock_polarity_o;
    control_view[CTL_WIDE]       = wide_divider_select_r;
    control_view[CTL_WAKE]       = wake_on_receive_enable_r;
    control_view[CTL_DETECT]     = auto_rate_detect_enable_r;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      OFS_CONTROL:     rd_data[7:0] = control_view;
      OFS_DIVISOR_LOW: rd_data[7:0] = divisor_r[7:0];
      OFS_DIVISOR_HI:  rd_data[7:0] = divisor_r[15:8];
      OFS_MODE: begin
        rd_data[MODE_SYNC]     = sync_mode_o;
        rd_data[MODE_HIGH_SPD] = high_speed_select_r;
      end
      OFS_IRQ_STATUS:  rd_data[IRQ_W-1:0] = irq_status_r;
      OFS_IRQ_MASK:    rd_data[IRQ_W-1:0] = irq_mask_r;
      OFS_COUNT_LOW:   rd_data[7:0] = divider_count[7:0];
      OFS_COUNT_HI:    rd_data[7:0] = divider_count[15:8];
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_o <= rd_data;
    end
  end

endmodule

// >>> rtl/rate_gen_pkg.sv
package rate_gen_pkg;

  // ************************************************************
  // register byte offsets on the bus
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_DIVISOR_LOW = 8'h04;
  localparam logic [7:0] OFS_DIVISOR_HI  = 8'h08;
  localparam logic [7:0] OFS_MODE        = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
  localparam logic [7:0] OFS_COUNT_LOW   = 8'h18;
  localparam logic [7:0] OFS_COUNT_HI    = 8'h1c;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_DETECT_OVF = 7;
  localparam int CTL_RX_IDLE    = 6;
  localparam int CTL_POLARITY   = 4;
  localparam int CTL_WIDE       = 3;
  localparam int CTL_WAKE       = 1;
  localparam int CTL_DETECT     = 0;
  localparam int MODE_SYNC      = 0;
  localparam int MODE_HIGH_SPD  = 1;
  localparam int IRQ_WAKE       = 0;
  localparam int IRQ_DET_DONE   = 1;
  localparam int IRQ_DET_OVF    = 2;
  localparam int IRQ_W          = 3;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [15:0]      DIVISOR_RST  = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic             BIT_RST      = 1'h0;
  localparam logic             RX_IDLE_LVL  = 1'h1;

  // ************************************************************
  // prescale multipliers in clock cycles
  // ************************************************************
  localparam logic [6:0] PRE_ASYNC_NARROW      = 7'h40;
  localparam logic [6:0] PRE_ASYNC_NARROW_FAST = 7'h10;
  localparam logic [6:0] PRE_ASYNC_WIDE        = 7'h10;
  localparam logic [6:0] PRE_ASYNC_WIDE_FAST   = 7'h04;
  localparam logic [6:0] PRE_SYNC              = 7'h04;

  // ************************************************************
  // rate detection sequence
  // ************************************************************
  typedef enum {
    DET_IDLE,
    DET_ARMED,
    DET_MEASURE
  } detect_state_t;

endpackage

// >>> rtl/pin_sync.sv
module pin_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin in, synchronised level out
  input  wire logic pin_i,
  output logic      level_o
);
  import rate_gen_pkg::*;

  logic meta_r;

  // line idles high, so reset to the idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r  <= RX_IDLE_LVL;
      level_o <= RX_IDLE_LVL;
    end else begin
      meta_r  <= pin_i;
      level_o <= meta_r;
    end
  end

endmodule

// >>> rtl/rate_divider.sv
module rate_divider
  import rate_gen_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // configuration
  input  wire logic        clear_i,
  input  wire logic        sync_mode_i,
  input  wire logic        wide_i,
  input  wire logic        high_speed_i,
  input  wire logic [15:0] divisor_i,
  // timing outputs
  output logic             pre_tick_o,
  output logic             tick_o,
  output logic [15:0]      count_o
);

  logic [6:0]  pre_len;
  logic [6:0]  pre_cnt_r;
  logic [15:0] period;
  logic        wrap;

  // ************************************************************
  // prescale select
  // ************************************************************
  always_comb begin
    if (sync_mode_i) begin
      pre_len = PRE_SYNC;
    end else begin
      case ({wide_i, high_speed_i})
        2'b00:   pre_len = PRE_ASYNC_NARROW;
        2'b01:   pre_len = PRE_ASYNC_NARROW_FAST;
        2'b10:   pre_len = PRE_ASYNC_WIDE;
        default: pre_len = PRE_ASYNC_WIDE_FAST;
      endcase
    end
  end

  // narrow mode only looks at the low divisor byte
  assign period     = wide_i ? divisor_i : {8'h00, divisor_i[7:0]};
  assign pre_tick_o = (pre_cnt_r == pre_len - 7'h01);
  assign wrap       = pre_tick_o && (count_o >= period);

  // ************************************************************
  // free running prescaler and timer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || pre_tick_o) begin
      pre_cnt_r <= 7'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= 16'h0000;
    end else if (wrap) begin
      count_o <= 16'h0000;
    end else if (pre_tick_o) begin
      count_o <= count_o + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap;
    end
  end

endmodule

// >>> tb/rate_gen_assertions.sv
module rate_gen_assertions
  import rate_gen_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // receive side and outputs
  input wire logic        rx_pin_i,
  input wire logic        receive_idle_flag_i,
  input wire logic        rate_tick_o,
  input wire logic        receive_interrupt_flag_set_o,
  input wire logic        clock_polarity_o,
  input wire logic        sync_mode_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helpers
  // ****************
  logic req;
  logic wr;
  assign req = cyc_i && stb_i && !ack_o;
  // a write takes effect on the edge where ack is seen high
  assign wr  = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // properties
  // ****************
  a_ack_follows_req: assert property (req |=> ack_o)
    else $error("no ack one cycle after a request");
  a_ack_single_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  a_unmapped_reads_zero: assert property (
    req && !we_i && adr_i >= 8'h20 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mode_bit_update: assert property (
    wr && adr_i == OFS_MODE |=> sync_mode_o == $past(dat_i[MODE_SYNC]))
    else $error("mode bit not taken from write");
  a_polarity_update: assert property (wr && adr_i == OFS_CONTROL
    |=> clock_polarity_o == $past(dat_i[CTL_POLARITY]))
    else $error("polarity bit not taken from write");
  a_tick_min_spacing: assert property (
    rate_tick_o |=> !rate_tick_o [*3])
    else $error("rate ticks closer than four clocks");
  a_divisor_write_clears: assert property (
    wr && (adr_i == OFS_DIVISOR_LOW || adr_i == OFS_DIVISOR_HI)
    |=> ##1 !rate_tick_o [*2])
    else $error("tick too soon after divisor write");
  a_wake_pulse_single: assert property (
    receive_interrupt_flag_set_o |=> !receive_interrupt_flag_set_o)
    else $error("wake flag pulse longer than one cycle");
  a_wake_async_only: assert property (
    receive_interrupt_flag_set_o |-> !$past(sync_mode_o))
    else $error("wake event in synchronous mode");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !irq_o && !rate_tick_o && !sync_mode_o)
    else $error("outputs active after reset edge");
  c_tick: cover property (rate_tick_o);
  c_wake: cover property (receive_interrupt_flag_set_o);
  c_irq: cover property ($rose(irq_o));
endmodule

bind serial_baud_rate_generator rate_gen_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rx_pin_i(rx_pin_i),
  .receive_idle_flag_i(receive_idle_flag_i), .rate_tick_o(rate_tick_o),
  .receive_interrupt_flag_set_o(receive_interrupt_flag_set_o),
  .clock_polarity_o(clock_polarity_o), .sync_mode_o(sync_mode_o),
  .irq_o(irq_o));

// >>> tb/tb.sv
module tb
  import rate_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        rx_pin_i = 1'b1;
  logic        idle_i = 1'b1;
  logic [31:0] dat_o;
  logic        ack_o, tick_o, wake_o, pol_o, sync_o, irq_o;
  logic [31:0] seed = 32'hf794;
  int          errors = 0;
  int          n_checks = 0;
  always #4 clk_i = ~clk_i;
  serial_baud_rate_generator dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_pin_i(rx_pin_i),
    .receive_idle_flag_i(idle_i), .rate_tick_o(tick_o),
    .receive_interrupt_flag_set_o(wake_o), .clock_polarity_o(pol_o),
    .sync_mode_o(sync_o), .irq_o(irq_o));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // prescale in clocks; the high speed bit means nothing in sync mode
  function automatic int pre_of(logic s, logic h, logic w);
    if (s) return 4;
    if (w) return h ? 4 : 16;
    return h ? 16 : 64;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int t;
    t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    chk("bus ack", 1, t < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick_o !== 1'b1 && n < 20000);
  endtask
  // drops the pin for a while and counts wake pulses seen
  task automatic wake_try(output int t);
    t = 0;
    rx_pin_i <= 1'b0;
    repeat (10) begin
      @(posedge clk_i);
      if (wake_o === 1'b1) t++;
    end
    rx_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    int          n, p;
    logic [31:0] q;
    logic [15:0] dv;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      wb(8'(4 * i), 1'b0, 32'h0, 4'hf, q);
      chk("reset value", i == 0 ? 32'h40 : 32'h0, q);
    end
    idle_i <= 1'b0;
    wb(OFS_CONTROL, 1'b0, 32'h0, 4'hf, q);
    chk("idle bit", 32'h0, q);
    idle_i <= 1'b1;
    wait_tick(n);
    wait_tick(n);
    chk("reset period", 64, n);
    for (int c = 0; c < 8; c++) begin
      q = rnd();
      dv = {7'h0, q[8], 5'h0, q[2:0]};
      wb(OFS_MODE, 1'b1, {30'h0, c[1], c[2]}, 4'h1, q);
      wb(OFS_CONTROL, 1'b1, {28'h0, c[0], 3'h0}, 4'h1, q);
      wb(OFS_DIVISOR_LOW, 1'b1, {24'h0, dv[7:0]}, 4'h1, q);
      wb(OFS_DIVISOR_HI, 1'b1, {24'h0, dv[15:8]}, 4'h1, q);
      p = pre_of(c[2], c[1], c[0]) * ((c[0] ? dv : dv[7:0]) + 1);
      wait_tick(n);
      chk("first tick", 1, n >= p - 1 && n <= p + 2);
      wait_tick(n);
      chk("period", p, n);
    end
    wb(OFS_DIVISOR_HI, 1'b0, 32'h0, 4'hf, q);
    chk("divisor high", {24'h0, dv[15:8]}, q);
    wb(OFS_DIVISOR_LOW, 1'b1, 32'h3, 4'h1, q);
    wb(OFS_COUNT_LOW, 1'b0, 32'h0, 4'hf, q);
    chk("count cleared", 32'h0, q);
    wb(OFS_MODE, 1'b1, 32'h0, 4'h1, q);
    wb(OFS_CONTROL, 1'b1, 32'h10, 4'he, q);
    chk("polarity no sel", 0, pol_o);
    wb(OFS_CONTROL, 1'b1, 32'h10, 4'h1, q);
    chk("polarity", 1, pol_o);
    wb(8'h20, 1'b1, 32'hff, 4'hf, q);
    wb(8'h20, 1'b0, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
    wb(OFS_CONTROL, 1'b0, 32'h0, 4'hf, q);
    chk("control kept", 32'h58 & 32'h50, q);
    wb(OFS_IRQ_MASK, 1'b1, 32'h1, 4'h1, q);
    wb(OFS_CONTROL, 1'b1, 32'h02, 4'h1, q);
    wake_try(n);
    chk("wake pulses", 1, n);
    chk("irq raised", 1, irq_o);
    wb(OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf, q);
    chk("wake status", 32'h1, q);
    wb(OFS_CONTROL, 1'b0, 32'h0, 4'hf, q);
    chk("wake self clear", 32'h40, q);
    wb(OFS_IRQ_MASK, 1'b1, 32'h0, 4'h1, q);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 0, irq_o);
    wb(OFS_IRQ_STATUS, 1'b1, 32'h1, 4'h1, q);
    wb(OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf, q);
    chk("status cleared", 32'h0, q);
    wake_try(n);
    chk("wake off", 0, n);
    wb(OFS_MODE, 1'b1, 32'h1, 4'h1, q);
    chk("sync mode", 1, sync_o);
    wb(OFS_CONTROL, 1'b1, 32'h02, 4'h1, q);
    wake_try(n);
    chk("wake in sync", 0, n);
    wb(OFS_CONTROL, 1'b1, 32'h0, 4'h1, q);
    wb(OFS_MODE, 1'b1, 32'h0, 4'h1, q);
    wb(OFS_CONTROL, 1'b1, 32'h01, 4'h1, q);
    repeat (3) @(posedge clk_i);
    rx_pin_i <= 1'b0;
    repeat (384) @(posedge clk_i);
    rx_pin_i <= 1'b1;
    repeat (200) @(posedge clk_i);
    wb(OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf, q);
    chk("detect done", 32'h2, q);
    wb(OFS_CONTROL, 1'b0, 32'h0, 4'hf, q);
    chk("detect self clear", 32'h40, q);
    wb(OFS_DIVISOR_LOW, 1'b0, 32'h0, 4'hf, q);
    chk("measured", 1, q >= 32'h4 && q <= 32'h6);
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    give_verdict();
  end
endmodule
